// >>> mdca_top.sv
/*
  Multi-device clock alignment: divide-by-four timing clock generator,
  automatic master/slave alignment, manual software and hardware stalls,
  and the commit path from buffered to active configuration and data.
  Assumes the serial port outside holds the buffered words stable around
  a commit and gives a one-cycle status_read pulse when config two is read.
*/
`timescale 1ns/1ps
`default_nettype none
module mdca_top #(
  parameter int DATA_W = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire mdca_pkg::mdca_function_config_one_t buf_function_config_one,
  input wire mdca_pkg::mdca_function_config_two_t buf_function_config_two,
  input wire logic [DATA_W-1:0] buf_data,
  input wire logic commit_pin,
  input wire logic align_pulse_in_pin,
  input wire logic status_read,
  output logic timing_clk,
  output logic align_pulse_out,
  output var mdca_pkg::mdca_function_config_one_t active_function_config_one,
  output var mdca_pkg::mdca_function_config_two_t active_function_config_two,
  output logic [DATA_W-1:0] active_data,
  output logic align_status,
  output logic commit_done
);

  // phase to a 0..3 index and back, used for offset arithmetic
  function automatic logic [1:0] ph_index(input mdca_pkg::mdca_phase_t p);
    ph_index = {p[1], p[1] ^ p[0]};
  endfunction

  function automatic mdca_pkg::mdca_phase_t ph_add(input mdca_pkg::mdca_phase_t p,
                                                   input logic [1:0] n);
    logic [1:0] i;
    i = ph_index(p) + n;
    ph_add = mdca_pkg::mdca_phase_t'({i[1], i[1] ^ i[0]});
  endfunction

  // timing clock is high for the first half of the four phases
  function automatic logic ph_high(input mdca_pkg::mdca_phase_t p);
    ph_high = (p == mdca_pkg::MDCA_PH0) || (p == mdca_pkg::MDCA_PH1);
  endfunction

  logic [1:0] pins_sync;
  logic commit_sync;
  logic pulse_sync;

  // both pins are asynchronous to the system clock
  mdca_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .async_in({commit_pin, align_pulse_in_pin}),
    .sync_out(pins_sync)
  );

  assign commit_sync = pins_sync[1];
  assign pulse_sync = pins_sync[0];

  mdca_pkg::mdca_phase_t phase_reg, phase_next;
  logic tclk_reg, tclk_next;
  logic pout_reg, pout_next;
  logic pulse_prev_reg, pulse_prev_next;
  logic commit_prev_reg, commit_prev_next;
  logic sw_stall_reg, sw_stall_next;
  logic status_reg, status_next;
  logic done_reg, done_next;
  mdca_pkg::mdca_function_config_one_t cfg_one_reg, cfg_one_next;
  mdca_pkg::mdca_function_config_two_t cfg_two_reg, cfg_two_next;
  logic [DATA_W-1:0] data_reg, data_next;

  logic auto_on;
  logic is_master;
  logic pulse_edge;
  mdca_pkg::mdca_phase_t expect_phase;
  logic mismatch;
  logic hw_stall;
  logic stall;
  logic tick;
  logic xfer;

  // alignment decisions, all from active (committed) configuration
  always_comb begin
    auto_on = cfg_two_reg.auto_en;
    is_master = cfg_two_reg.master_en;
    pulse_edge = pulse_sync && !pulse_prev_reg;
    // the slave expects the master's launch phase advanced by the travel delay
    // plus the receive latency; a delay that straddles a boundary is covered by the code
    expect_phase = ph_add(mdca_pkg::MDCA_PULSE_PHASE,
                          cfg_two_reg.offset + mdca_pkg::MDCA_RX_LATENCY);
    mismatch = auto_on && !is_master && pulse_edge && (phase_reg != expect_phase);
    hw_stall = cfg_one_reg.hw_align && pulse_edge;
    // one stall per pulse shifts a quarter period, so three pulses at most
    stall = mismatch || hw_stall || sw_stall_reg;
    // active timing edge: the generator is about to enter phase zero
    tick = (phase_reg == mdca_pkg::MDCA_PH3) && !stall;
    // strobe oversampled on timing edges, so it must outlast a period
    xfer = tick && commit_sync && !commit_prev_reg;
  end

  // clock generator and pulse launch
  always_comb begin
    case (phase_reg)
      mdca_pkg::MDCA_PH0: phase_next = mdca_pkg::MDCA_PH1;
      mdca_pkg::MDCA_PH1: phase_next = mdca_pkg::MDCA_PH2;
      mdca_pkg::MDCA_PH2: phase_next = mdca_pkg::MDCA_PH3;
      mdca_pkg::MDCA_PH3: phase_next = mdca_pkg::MDCA_PH0;
      default: phase_next = mdca_pkg::MDCA_PHASE_RESET;
    endcase
    if (stall) begin
      phase_next = phase_reg;
    end
    tclk_next = ph_high(phase_next);
    // a held phase zero must not stretch the pulse past one clock
    pout_next = auto_on && is_master && !stall &&
                (phase_next == mdca_pkg::MDCA_PULSE_PHASE);
    pulse_prev_next = pulse_sync;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_reg <= mdca_pkg::MDCA_PHASE_RESET;
      tclk_reg <= 1'b0;
      pout_reg <= 1'b0;
      pulse_prev_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      tclk_reg <= tclk_next;
      pout_reg <= pout_next;
      pulse_prev_reg <= pulse_prev_next;
    end
  end

  // commit path; buffered words do nothing until the transfer
  always_comb begin
    cfg_one_next = cfg_one_reg;
    cfg_two_next = cfg_two_reg;
    data_next = data_reg;
    commit_prev_next = commit_prev_reg;
    done_next = xfer;
    // the software stall lasts exactly the cycle after the clearing commit
    sw_stall_next = xfer && cfg_one_reg.sw_align &&
                    !buf_function_config_one.sw_align;
    if (tick) begin
      commit_prev_next = commit_sync;
    end
    if (xfer) begin
      cfg_one_next = buf_function_config_one;
      cfg_two_next = buf_function_config_two;
      data_next = buf_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_one_reg <= mdca_pkg::MDCA_FUNCTION_CONFIG_ONE_RESET;
      cfg_two_reg <= mdca_pkg::MDCA_FUNCTION_CONFIG_TWO_RESET;
      data_reg <= '0;
      commit_prev_reg <= 1'b0;
      done_reg <= 1'b0;
      sw_stall_reg <= 1'b0;
    end else begin
      cfg_one_reg <= cfg_one_next;
      cfg_two_reg <= cfg_two_next;
      data_reg <= data_next;
      commit_prev_reg <= commit_prev_next;
      done_reg <= done_next;
      sw_stall_reg <= sw_stall_next;
    end
  end

  // sticky status: a new mismatch beats the read that clears it
  always_comb begin
    status_next = status_reg;
    if (status_read) begin
      status_next = 1'b0;
    end
    if (mismatch) begin
      status_next = 1'b1;
    end
    if (cfg_two_reg.mask) begin
      status_next = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign timing_clk = tclk_reg;
  assign align_pulse_out = pout_reg;
  assign active_function_config_one = cfg_one_reg;
  assign active_function_config_two = cfg_two_reg;
  assign active_data = data_reg;
  assign align_status = status_reg;
  assign commit_done = done_reg;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_rise_run;
    $rose(tclk_reg) ##0 (!stall)[*4];
  endsequence

  sequence s_master_run;
    pout_reg ##0 (auto_on && is_master && !stall)[*4];
  endsequence

  chk_tclk_period: assert property (s_rise_run |=> $rose(tclk_reg))
    else $error("timing clock period is not four system clocks");
  chk_pulse_width: assert property (pout_reg |=> !pout_reg)
    else $error("alignment pulse wider than one system clock");
  chk_pulse_period: assert property (s_master_run |=> pout_reg)
    else $error("master pulse not repeated every four clocks");
  chk_slave_quiet: assert property (!(auto_on && is_master) |=> !pout_reg)
    else $error("pulse driven while not an automatic master");
  chk_slave_stall: assert property (mismatch |=> phase_reg == $past(phase_reg))
    else $error("slave mismatch did not hold the phase");
  chk_hw_stall: assert property (hw_stall |=> phase_reg == $past(phase_reg))
    else $error("hardware edge did not stall the generator");
  chk_sw_stall: assert property (
      (xfer && cfg_one_reg.sw_align && !buf_function_config_one.sw_align)
      |=> ##1 phase_reg == $past(phase_reg))
    else $error("clearing commit did not stall one cycle");
  chk_status_set: assert property ((mismatch && !cfg_two_reg.mask) |=> status_reg)
    else $error("status not raised on mismatch");
  chk_status_mask: assert property (cfg_two_reg.mask |=> !status_reg)
    else $error("masked status went high");
  chk_commit_edge: assert property (xfer |=> phase_reg == mdca_pkg::MDCA_PH0)
    else $error("transfer not on a timing clock edge");
  chk_data_hold: assert property (!xfer |=> $stable(data_reg) && !done_reg)
    else $error("active data changed without a commit");
  chk_one_commit: assert property (xfer |=> !xfer[*4])
    else $error("two transfers for one strobe");

endmodule
`default_nettype wire

// >>> mdca_pkg.sv
/*
  Shared definitions for the multi-device clock alignment block: timing
  clock phase encoding, configuration layouts, reset values and fixed
  latencies. Assumes a single system clock domain and that the serial
  port logic outside presents the buffered configuration as plain words.
*/
package mdca_pkg;

  // gray-coded divide-by-four generator phases
  typedef enum logic [1:0] {
    MDCA_PH0 = 2'h0,
    MDCA_PH1 = 2'h1,
    MDCA_PH2 = 2'h3,
    MDCA_PH3 = 2'h2
  } mdca_phase_t;

  // config one: only the two alignment bits live here
  typedef struct packed {
    logic hw_align;
    logic sw_align;
  } mdca_function_config_one_t;

  // config two laid out at its bit positions 7..0
  typedef struct packed {
    logic auto_en;
    logic master_en;
    logic status;
    logic mask;
    logic [1:0] spare;
    logic [1:0] offset;
  } mdca_function_config_two_t;

  localparam mdca_function_config_one_t MDCA_FUNCTION_CONFIG_ONE_RESET = 2'h0;
  localparam mdca_function_config_two_t MDCA_FUNCTION_CONFIG_TWO_RESET = 8'h00;
  // parked in the last, low phase: the first edge out of reset is then a
  // real timing rise instead of a false one in the middle of a high half
  localparam mdca_phase_t MDCA_PHASE_RESET = MDCA_PH3;
  // phase on which the master launches its pulse
  localparam mdca_phase_t MDCA_PULSE_PHASE = MDCA_PH0;
  // system clocks between the launch flop and the slave seeing the pulse,
  // beyond the programmed travel delay: one for each of the two synchroniser stages
  localparam logic [1:0] MDCA_RX_LATENCY = 2'h2;
  localparam int MDCA_SYNC_STAGES = 2;

endpackage

// >>> mdca_sync.sv
/*
  Two-stage level synchroniser for pins coming from outside the system
  clock domain. Assumes the inputs are levels or pulses longer than one
  system clock; shorter glitches may be missed.
*/
`timescale 1ns/1ps
`default_nettype none
module mdca_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // first stage only feeds the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// >>> mdca_peer.sv
/*
  Peer device model: a free-running alignment master on the shared system
  clock, its pulse delayed on the wire by a chosen number of clocks.
  Assumes the same clock and reset as the block under test.
*/
`timescale 1ns/1ps
`default_nettype none
module mdca_peer (
  input wire logic clock,
  input wire logic rst,
  input wire logic en,
  input wire logic [1:0] delay,
  input wire logic skip,
  output logic pulse_out,
  output logic tc_out
);
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  logic [3:0] hist_reg;
  logic [3:0] hist_next;
  // phase steps each clock; skip slips it one cycle to force misalignment
  always_comb begin
    ph_next = skip ? ph_reg : ph_reg + 2'h1;
    hist_next = {hist_reg[2:0], ph_next == 2'h0};
  end
  // launch flops for phase and pulse history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_reg <= 2'h0;
      hist_reg <= 4'h0;
    end else begin
      ph_reg <= ph_next;
      hist_reg <= hist_next;
    end
  end
  // driven low when disabled so no stray edges reach the pin
  assign pulse_out = en & hist_reg[delay];
  assign tc_out = ~ph_reg[1];
endmodule
`default_nettype wire

// >>> mdca_top_tb.sv
/*
  Self-checking bench for the alignment block with one peer master.
  Assumes the package, design and peer model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module mdca_top_tb;
  logic clock = 1'h0;
  logic rst = 1'h1;
  mdca_pkg::mdca_function_config_one_t buf_cfg_one = 2'h0;
  mdca_pkg::mdca_function_config_two_t buf_cfg_two = 8'h00;
  logic [31:0] buf_data = 32'h0;
  logic commit_pin = 1'h0;
  logic man_pulse = 1'h0;
  logic status_read = 1'h0;
  logic peer_en = 1'h0;
  logic [1:0] peer_delay = 2'h0;
  logic peer_skip = 1'h0;
  logic tc_prev = 1'h0;
  logic peer_pulse, peer_tc, timing_clk, align_pulse_out, align_status, commit_done;
  mdca_pkg::mdca_function_config_one_t active_cfg_one;
  mdca_pkg::mdca_function_config_two_t active_cfg_two;
  logic [31:0] active_data;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int rise_mod = 0;
  int seed = 32'hbedb;

  always #20 clock = ~clock;

  mdca_top dut_u (.clock(clock), .rst(rst), .buf_function_config_one(buf_cfg_one),
    .buf_function_config_two(buf_cfg_two),
    .buf_data(buf_data), .commit_pin(commit_pin), .align_pulse_in_pin(peer_pulse | man_pulse),
    .status_read(status_read), .timing_clk(timing_clk), .align_pulse_out(align_pulse_out),
    .active_function_config_one(active_cfg_one), .active_function_config_two(active_cfg_two),
    .active_data(active_data),
    .align_status(align_status), .commit_done(commit_done));

  mdca_peer peer_u (.clock(clock), .rst(rst), .en(peer_en), .delay(peer_delay),
    .skip(peer_skip), .pulse_out(peer_pulse), .tc_out(peer_tc));

  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  // timing clock rise position mod 4 shows every stall; also the hang guard
  always @(negedge clock) begin
    cyc++;
    if (timing_clk === 1'h1 && tc_prev === 1'h0) rise_mod = cyc % 4;
    tc_prev = timing_clk;
    if (cyc > 4000) begin
      miscompares++;
      $display("mismatch %0t timeout", $time);
      wrap_up();
    end
  end

  // strobe held well past one timing period, then low long enough to rearm
  task automatic do_commit(input logic [1:0] f1, input logic [7:0] f2, input logic [31:0] d);
    logic [31:0] old;
    logic ok;
    int n;
    old = active_data;
    n = 0;
    buf_cfg_one = f1;
    buf_cfg_two = f2;
    buf_data = d;
    commit_pin = 1'h1;
    @(negedge clock);
    while (commit_done !== 1'h1 && n < 10) begin
      chk(active_data === old, "early transfer");
      n++;
      @(negedge clock);
    end
    ok = {active_cfg_one, active_cfg_two, active_data} === {f1, f2, d};
    chk(commit_done === 1'h1 && ok, "transfer");
    chk(n >= 2, "transfer before strobe was synchronised");
    for (int i = 0; i < 12; i++) begin
      @(negedge clock);
      if (i == 4) commit_pin = 1'h0;
      chk(commit_done === 1'h0, "second transfer");
    end
  endtask

  // one-cycle read of the status bit
  task automatic pulse_read();
    status_read = 1'h1;
    @(negedge clock);
    status_read = 1'h0;
    @(negedge clock);
  endtask

  // main sequence: divider, commits, master pulses, stalls, slave alignment
  initial begin
    logic tcs [0:11];
    logic [31:0] r;
    logic [7:0] f2;
    int m0;
    int cnt;
    repeat (8) @(negedge clock);
    rst = 1'h0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clock);
      tcs[i] = timing_clk;
    end
    for (int i = 0; i < 8; i++) begin
      chk(tcs[i] === tcs[i + 4] && tcs[i] !== tcs[i + 2], "divider");
    end
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      do_commit(r[1:0], r[9:2], $random(seed));
    end
    // master only with auto on; slave or auto off stays quiet
    for (int j = 0; j < 3; j++) begin
      f2 = (j == 0) ? 8'hC0 : (j == 1) ? 8'h40 : 8'h80;
      do_commit(2'h0, f2, 32'h0);
      cnt = 0;
      for (int i = 0; i < 16; i++) begin
        @(negedge clock);
        if (align_pulse_out === 1'h1) cnt++;
      end
      chk(cnt === ((j == 0) ? 4 : 0), "master pulses");
    end
    do_commit(2'h1, 8'h00, 32'h0);
    m0 = rise_mod;
    do_commit(2'h0, 8'h00, 32'h0);
    chk(rise_mod === (m0 + 1) % 4, "soft stall");
    do_commit(2'h0, 8'h00, 32'h0);
    chk(rise_mod === (m0 + 1) % 4, "stray soft stall");
    // pin stalls only while the hardware bit is active
    for (int k = 0; k < 3; k++) begin
      do_commit({k < 2, 1'h0}, 8'h00, 32'h0);
      m0 = rise_mod;
      man_pulse = 1'h1;
      repeat (3) @(negedge clock);
      man_pulse = 1'h0;
      repeat (10) @(negedge clock);
      chk(rise_mod === (m0 + (k < 2)) % 4, "pin stall");
    end
    // slave per offset; peer slips once, offset 3 runs masked
    for (int o = 0; o < 4; o++) begin
      f2 = {1'h1, 2'h0, o == 3, 2'h0, o[1:0]};
      peer_delay = o[1:0];
      peer_en = 1'h1;
      do_commit(2'h0, f2, 32'h0);
      repeat (20) @(negedge clock);
      pulse_read();
      peer_skip = 1'h1;
      @(negedge clock);
      peer_skip = 1'h0;
      cnt = 0;
      for (int i = 0; i < 24; i++) begin
        @(negedge clock);
        if (align_status === 1'h1) cnt++;
        if (i >= 14) chk(timing_clk === peer_tc, "slave phase");
      end
      chk((cnt > 0) === (o != 3), "status flag");
      pulse_read();
      chk(align_status === 1'h0, "status clear");
      peer_en = 1'h0;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
